// File: hw/seq_pkg.sv
`default_nettype none
package seq_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] ctrl_off = 4'h0;
  localparam logic [3:0] status_off = 4'h4;
  localparam logic [3:0] state_off = 4'h8;
  localparam logic [31:0] ctrl_rst = 32'h0000_0000;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ctrl_run_bit = 0;
  localparam int ctrl_nonpipe_bit = 1;
  localparam int status_active_bit = 8;

  // Clock output vector bit positions
  localparam int ck_1a = 0;
  localparam int ck_1b = 1;
  localparam int ck_2a = 2;
  localparam int ck_2b = 3;
  localparam int ck_3a = 4;
  localparam int ck_3b = 5;
  localparam int ck_a = 6;
  localparam int ck_b = 7;
  localparam logic [7:0] clk_rst = 8'h00;

  // ----------------------------------------
  // Sequencer states; power-on code is all zero
  // ----------------------------------------
  typedef enum logic [21:0] {
    st_init              = 22'h000000,
    st_free_a            = 22'h000001,
    st_free_b            = 22'h000002,
    st_fetch_start_pipe  = 22'h000004,
    st_s1_second_half    = 22'h000008,
    st_s12_first_half    = 22'h000010,
    st_s12_second_half   = 22'h000020,
    st_all_first_half    = 22'h000040,
    st_all_second_half   = 22'h000080,
    st_wait_a_pipe       = 22'h000100,
    st_wait_pipe         = 22'h000200,
    st_s2_first_half     = 22'h000400,
    st_s23_second_half   = 22'h000800,
    st_s3_first_half     = 22'h001000,
    st_s3_second_half    = 22'h002000,
    st_fetch_start_np    = 22'h004000,
    st_s1_second_half_np = 22'h008000,
    st_s2_first_half_np  = 22'h010000,
    st_s2_second_half_np = 22'h020000,
    st_s3_first_half_np  = 22'h040000,
    st_s3_second_half_np = 22'h080000,
    st_wait_a_np         = 22'h100000,
    st_wait_np           = 22'h200000
  } seq_state_t;

endpackage
`default_nettype wire

// File: hw/seq_regs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface seq_regs_if;
  logic sw_run;
  logic sw_nonpipe;
  logic [7:0] clocks;
  logic [21:0] state;

  modport regs (
    output sw_run,
    output sw_nonpipe,
    input clocks,
    input state
  );
  modport core (
    input sw_run,
    input sw_nonpipe,
    output clocks,
    output state
  );
endinterface
`default_nettype wire

// File: hw/seq_regs.sv
`timescale 1ns/1ps
`default_nettype none
module seq_regs (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core side
  seq_regs_if.regs rif
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [3:0] wr_addr;
    logic [31:0] ctrl;
    logic [31:0] rdata;
  } regs_state_t;

  regs_state_t q;
  regs_state_t d;
  logic take;

  function automatic logic [31:0] read_mux(input logic [3:0] a,
                                           input logic [31:0] ctrl);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      seq_pkg::ctrl_off: r = ctrl;
      seq_pkg::status_off: begin
        r[7:0] = rif.clocks;
        r[seq_pkg::status_active_bit] = (rif.state != 22'h000000) &&
          (rif.clocks[seq_pkg::ck_1a +: 6] != 6'h00);
      end
      seq_pkg::state_off: r[21:0] = rif.state;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Next value
  // ----------------------------------------
  always_comb begin
    d = q;
    // Whole-word transfers only; hsize is not checked
    take = hsel && htrans[1] && hready;
    d.wr_pend = take && hwrite;
    d.wr_addr = haddr[3:0];
    if (q.wr_pend && q.wr_addr == seq_pkg::ctrl_off) begin
      d.ctrl = {30'h0, hwdata[seq_pkg::ctrl_nonpipe_bit],
                hwdata[seq_pkg::ctrl_run_bit]};
    end
    // Read sees a write finishing in the same cycle
    if (take && !hwrite) begin
      d.rdata = read_mux(haddr[3:0], d.ctrl);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{wr_pend: 1'b0, wr_addr: 4'h0, ctrl: seq_pkg::ctrl_rst,
             rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rif.sw_run = q.ctrl[seq_pkg::ctrl_run_bit];
  assign rif.sw_nonpipe = q.ctrl[seq_pkg::ctrl_nonpipe_bit];

  logic unused_ok;
  assign unused_ok = ^{haddr[31:4], hsize, hwdata[31:2]};

endmodule
`default_nettype wire

// File: hw/cpu_stage_clock_sequencer.sv
// Contract
// R01 - Reset sends the sequencer to power-on state from any state.
// R02 - Power-on goes to free-run A, then free-run B, unconditionally.
// R03 - With run inactive, alternate free-run A and B; no stage clocks.
// R04 - Nonpipe select high when run rises selects nonpipelined sequence.
// R05 - Nonpipe select low when run rises selects pipelined sequence.
// R06 - Run enters one of two fetch-start states; identical clocks.
// R07 - Wait states encoded apart from free-run B despite same outputs.
// R08 - All-stages second half: one exit on enabled irq, other otherwise.
// R09 - Stage-3 early clock only in all-first, s3-first, s3-first-np.
// R10 - Entries into all-first, s3-first and s3-first-np as specified.
// R11 - S12 and all-stages second halves go to fetch-start on irq.
// R12 - Exactly one successor per input combination; no illegal state.
// R13 - Free clocks half rate, mutually inverted, low during reset.
// R14 - Power-on state is all state and output bits zero.
// R15 - Enabled wait holds a wait state until wait deasserts.
// R16 - Enabled irq skips update clocks, beats wait, restarts stage 1.
// R17 - Clock outputs registered, decoded from state only.
// R18 - Driver syncs inputs and sets mode select before raising run.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cpu_stage_clock_sequencer (
  // Clock (sequencer_clock) and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Control inputs, already synchronous to hclk
  input wire logic run_in,
  input wire logic nonpipe_select,
  input wire logic irq_in,
  input wire logic irq_enable,
  input wire logic wait_in,
  input wire logic wait_enable,
  // Stage clocks
  output logic stage1_early_clock,
  output logic ir_update_clock,
  output logic stage2_early_clock,
  output logic alu_update_clock,
  output logic stage3_early_clock,
  output logic stage3_late_clock,
  // Free-running clocks
  output logic free_a_clock,
  output logic free_b_clock
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    seq_pkg::seq_state_t st;
    logic [7:0] clk;
  } seq_core_t;

  seq_core_t q;
  seq_core_t d;
  logic run;
  logic nonpipe;
  logic irq_take;
  logic wait_take;

  seq_regs_if rif ();

  // ----------------------------------------
  // Request qualification
  // ----------------------------------------
  // Enable gates entry only; a held wait ignores it [R15] [R16]
  function automatic logic qualified(input logic req_in,
                                     input logic en_in);
    return req_in && en_in;
  endfunction

  // ----------------------------------------
  // Clock decode
  // ----------------------------------------
  // Moore decode: clocks depend on the state alone [R17]
  function automatic logic [7:0] clocks_of(input seq_pkg::seq_state_t s);
    logic [7:0] c;
    c = 8'h00;
    case (s)
      seq_pkg::st_init: c = 8'h00; // [R14]
      seq_pkg::st_free_a, seq_pkg::st_wait_a_pipe,
      seq_pkg::st_wait_a_np: begin
        c[seq_pkg::ck_a] = 1'b1; // [R03]
      end
      seq_pkg::st_free_b, seq_pkg::st_wait_pipe,
      seq_pkg::st_wait_np: begin
        c[seq_pkg::ck_b] = 1'b1; // [R07]
      end
      seq_pkg::st_fetch_start_pipe, seq_pkg::st_fetch_start_np: begin
        c[seq_pkg::ck_1a] = 1'b1; // [R06]
        c[seq_pkg::ck_a] = 1'b1;
      end
      seq_pkg::st_s1_second_half, seq_pkg::st_s1_second_half_np: begin
        c[seq_pkg::ck_1b] = 1'b1;
        c[seq_pkg::ck_b] = 1'b1;
      end
      seq_pkg::st_s12_first_half: begin
        c[seq_pkg::ck_1a] = 1'b1;
        c[seq_pkg::ck_2a] = 1'b1;
        c[seq_pkg::ck_a] = 1'b1;
      end
      seq_pkg::st_s12_second_half: begin
        c[seq_pkg::ck_1b] = 1'b1;
        c[seq_pkg::ck_2b] = 1'b1;
        c[seq_pkg::ck_b] = 1'b1;
      end
      seq_pkg::st_all_first_half: begin
        c[seq_pkg::ck_1a] = 1'b1;
        c[seq_pkg::ck_2a] = 1'b1;
        c[seq_pkg::ck_3a] = 1'b1; // [R09]
        c[seq_pkg::ck_a] = 1'b1;
      end
      seq_pkg::st_all_second_half: begin
        c[seq_pkg::ck_1b] = 1'b1;
        c[seq_pkg::ck_2b] = 1'b1;
        c[seq_pkg::ck_3b] = 1'b1;
        c[seq_pkg::ck_b] = 1'b1;
      end
      seq_pkg::st_s2_first_half, seq_pkg::st_s2_first_half_np: begin
        c[seq_pkg::ck_2a] = 1'b1;
        c[seq_pkg::ck_a] = 1'b1;
      end
      seq_pkg::st_s23_second_half: begin
        c[seq_pkg::ck_2b] = 1'b1;
        c[seq_pkg::ck_3b] = 1'b1;
        c[seq_pkg::ck_b] = 1'b1;
      end
      seq_pkg::st_s2_second_half_np: begin
        c[seq_pkg::ck_2b] = 1'b1;
        c[seq_pkg::ck_b] = 1'b1;
      end
      seq_pkg::st_s3_first_half, seq_pkg::st_s3_first_half_np: begin
        c[seq_pkg::ck_3a] = 1'b1; // [R09]
        c[seq_pkg::ck_a] = 1'b1;
      end
      seq_pkg::st_s3_second_half, seq_pkg::st_s3_second_half_np: begin
        c[seq_pkg::ck_3b] = 1'b1;
        c[seq_pkg::ck_b] = 1'b1;
      end
      default: c = 8'h00;
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    // Pin and register requests are merged; caller keeps them synced [R18]
    run = run_in || rif.sw_run;
    nonpipe = nonpipe_select || rif.sw_nonpipe;
    irq_take = qualified(irq_in, irq_enable);
    wait_take = qualified(wait_in, wait_enable);
    // Every state but power-on is A-half or B-half, so free clocks alternate [R13]
    case (q.st)
      seq_pkg::st_init: d.st = seq_pkg::st_free_a; // [R02]
      seq_pkg::st_free_a: d.st = seq_pkg::st_free_b; // [R02]
      seq_pkg::st_free_b: begin
        // Mode is fixed by which fetch-start state is entered
        if (!run) begin
          d.st = seq_pkg::st_free_a; // [R03]
        end else if (nonpipe) begin
          d.st = seq_pkg::st_fetch_start_np; // [R04] [R06]
        end else begin
          d.st = seq_pkg::st_fetch_start_pipe; // [R05] [R06]
        end
      end
      // Pipelined fill
      seq_pkg::st_fetch_start_pipe: d.st = seq_pkg::st_s1_second_half;
      seq_pkg::st_s1_second_half: d.st = seq_pkg::st_s12_first_half;
      seq_pkg::st_s12_first_half: d.st = seq_pkg::st_s12_second_half;
      seq_pkg::st_s12_second_half: begin
        if (irq_take) begin
          d.st = seq_pkg::st_fetch_start_pipe; // [R11] [R16]
        end else begin
          d.st = seq_pkg::st_all_first_half; // [R10]
        end
      end
      seq_pkg::st_all_first_half: d.st = seq_pkg::st_all_second_half;
      seq_pkg::st_all_second_half: begin
        // Interrupt checked ahead of wait and stop
        if (irq_take) begin
          d.st = seq_pkg::st_fetch_start_pipe; // [R08] [R11] [R16]
        end else if (wait_take) begin
          d.st = seq_pkg::st_wait_a_pipe; // [R08] [R15]
        end else if (!run) begin
          d.st = seq_pkg::st_s2_first_half; // [R08]
        end else begin
          d.st = seq_pkg::st_all_first_half; // [R08]
        end
      end
      // Wait pair keeps free clocks running while stalled
      seq_pkg::st_wait_a_pipe: d.st = seq_pkg::st_wait_pipe; // [R15]
      seq_pkg::st_wait_pipe: begin
        if (wait_in) begin
          d.st = seq_pkg::st_wait_a_pipe; // [R15]
        end else begin
          d.st = seq_pkg::st_all_first_half; // [R10]
        end
      end
      // Pipelined drain
      // No 23A state, so 3A stays confined to three states [R09]
      seq_pkg::st_s2_first_half: d.st = seq_pkg::st_s23_second_half;
      seq_pkg::st_s23_second_half: d.st = seq_pkg::st_s3_first_half; // [R10]
      seq_pkg::st_s3_first_half: d.st = seq_pkg::st_s3_second_half;
      seq_pkg::st_s3_second_half: d.st = seq_pkg::st_free_a;
      // Nonpipelined cycle
      seq_pkg::st_fetch_start_np: d.st = seq_pkg::st_s1_second_half_np;
      seq_pkg::st_s1_second_half_np: d.st = seq_pkg::st_s2_first_half_np;
      seq_pkg::st_s2_first_half_np: d.st = seq_pkg::st_s2_second_half_np;
      seq_pkg::st_s2_second_half_np: begin
        if (irq_take) begin
          d.st = seq_pkg::st_fetch_start_np; // [R16]
        end else begin
          d.st = seq_pkg::st_s3_first_half_np; // [R10]
        end
      end
      seq_pkg::st_s3_first_half_np: d.st = seq_pkg::st_s3_second_half_np;
      seq_pkg::st_s3_second_half_np: begin
        if (wait_take) begin
          d.st = seq_pkg::st_wait_a_np; // [R15]
        end else if (run) begin
          d.st = seq_pkg::st_fetch_start_np;
        end else begin
          d.st = seq_pkg::st_free_a;
        end
      end
      seq_pkg::st_wait_a_np: d.st = seq_pkg::st_wait_np; // [R15]
      seq_pkg::st_wait_np: begin
        if (wait_in) begin
          d.st = seq_pkg::st_wait_a_np; // [R15]
        end else begin
          d.st = seq_pkg::st_fetch_start_np;
        end
      end
      // Unused codes fall back to power-on [R12]
      default: d.st = seq_pkg::st_init;
    endcase
    // Outputs registered alongside the state they decode [R17]
    d.clk = clocks_of(d.st);
  end

  // Async clear drops every clock output at once, whatever the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{st: seq_pkg::st_init, clk: seq_pkg::clk_rst}; // [R01] [R14]
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Register slave
  // ----------------------------------------
  seq_regs u_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rif(rif.regs)
  );

  // ----------------------------------------
  // Status feed
  // ----------------------------------------
  // Slave reads the registered copy, never the next value
  assign rif.clocks = q.clk;
  assign rif.state = q.st;

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign stage1_early_clock = q.clk[seq_pkg::ck_1a];
  assign ir_update_clock = q.clk[seq_pkg::ck_1b];
  assign stage2_early_clock = q.clk[seq_pkg::ck_2a];
  assign alu_update_clock = q.clk[seq_pkg::ck_2b];
  assign stage3_early_clock = q.clk[seq_pkg::ck_3a];
  assign stage3_late_clock = q.clk[seq_pkg::ck_3b];
  // Straight off flip-flops, so no decode glitch reaches the datapath
  assign free_a_clock = q.clk[seq_pkg::ck_a]; // [R13]
  assign free_b_clock = q.clk[seq_pkg::ck_b]; // [R13]

endmodule
`default_nettype wire

// File: verif/seq_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module seq_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control inputs
  input wire logic irq_in,
  input wire logic irq_enable,
  input wire logic wait_in,
  input wire logic wait_enable,
  // Stage and free clocks
  input wire logic stage1_early_clock,
  input wire logic ir_update_clock,
  input wire logic stage2_early_clock,
  input wire logic alu_update_clock,
  input wire logic stage3_early_clock,
  input wire logic stage3_late_clock,
  input wire logic free_a_clock,
  input wire logic free_b_clock
);
  // Stage clocks as 3b,3a,2b,2a,1b,1a
  wire logic [5:0] stg = {stage3_late_clock, stage3_early_clock,
    alu_update_clock, stage2_early_clock, ir_update_clock,
    stage1_early_clock};
  wire logic irq_ok = irq_in && irq_enable;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  reset_start_a: assert property (
    $rose(hresetn) |=> stg == 6'h00 && free_a_clock ##1
      stg == 6'h00 && free_b_clock)
    else $error("bad start after reset");
  free_inv_a: assert property (
    $past(hresetn) |-> free_a_clock != free_b_clock)
    else $error("free clocks not inverted");
  free_half_a: assert property (
    $past(hresetn) |=> free_a_clock != $past(free_a_clock))
    else $error("free clock missed a toggle");
  s3_early_a: assert property (
    stg[4] |-> free_a_clock && (stg == 6'h15 || stg == 6'h10))
    else $error("stage3 early clock in wrong state");
  irq_restart_a: assert property (
    stg[3] && !(stg[5] && !stg[1]) && irq_ok
      |=> stg == 6'h01 && free_a_clock)
    else $error("enabled irq did not restart stage 1");
  all_exit_a: assert property (
    stg == 6'h2a && !irq_ok |=> (stg & 6'h2a) == 6'h00)
    else $error("bad exit from all second half");
  s12_exit_a: assert property (
    stg == 6'h0a && !irq_ok |=> stg == 6'h15)
    else $error("s12 second half did not reach all first");
  s23_exit_a: assert property (
    stg == 6'h28 |=> stg == 6'h10 && free_a_clock)
    else $error("s23 second half did not reach s3 first");
  s2np_exit_a: assert property (
    stg == 6'h08 && !irq_ok |=> stg == 6'h10)
    else $error("np s2 second half did not reach s3");
  wait_entry_a: assert property (
    stg == 6'h2a && !irq_ok && wait_in && wait_enable
      |=> stg == 6'h00 ##1 stg == 6'h00)
    else $error("enabled wait not entered");
endmodule

bind cpu_stage_clock_sequencer seq_chk u_chk (
  .hclk, .hresetn, .irq_in, .irq_enable, .wait_in, .wait_enable,
  .stage1_early_clock, .ir_update_clock, .stage2_early_clock,
  .alu_update_clock, .stage3_early_clock, .stage3_late_clock,
  .free_a_clock, .free_b_clock
);
`default_nettype wire

// File: verif/cpu_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_ctl_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests, order run,np,irq,ien,wait,wen
  input wire logic [5:0] req,
  // Lines into the sequencer
  output logic [5:0] ctl
);
  // Run held back a cycle when the mode changes with it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 6'h00;
    end else begin
      ctl <= {req[5] & (ctl[5] | (ctl[4] == req[4])), req[4:0]};
    end
  end
endmodule
`default_nettype wire

// File: verif/cpu_stage_clock_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_stage_clock_sequencer_tb_top;
  // ----------
  // Signals
  // ----------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] req, ctl;
  wire [7:0] vec;
  logic [7:0] q[$];
  logic [31:0] rq[$];
  logic rd_dp = 1'b0;
  int mismatches, n_compared, seed;
  // Per step: request byte (bit7 = random irq/wait), clocks after edge
  // Pipelined wait exits to all first half, np wait to fetch start, not free A
  logic [15:0] tab [64] = '{
    16'h2080, 16'h2040, 16'h2080, 16'h2041, 16'h2082, 16'h2c45, 16'h208a,
    16'h2041, 16'h2082, 16'ha045, 16'h208a, 16'ha055, 16'h20aa, 16'h2c55,
    16'h20aa, 16'h2041, 16'h2082, 16'h2045, 16'h208a, 16'h2355, 16'h20aa,
    16'h2240, 16'h2080, 16'h2040, 16'h2080, 16'h2f55, 16'h20aa, 16'h2041,
    16'h2082, 16'h2045, 16'h208a, 16'h0055, 16'h00aa, 16'h0044, 16'h00a8,
    16'h0050, 16'h00a0, 16'h0040, 16'h0080,
    16'h3080, 16'h3040, 16'h3080, 16'h3041, 16'h3082, 16'h3c44, 16'h3088,
    16'h3041, 16'h3082, 16'h3044, 16'h3088, 16'h3350, 16'h30a0, 16'h3240,
    16'h3080, 16'h3040, 16'h3080, 16'h0041, 16'h0082, 16'h0044, 16'h0088,
    16'h0050, 16'h00a0, 16'h0040, 16'h0080};

  cpu_ctl_model i_ctl (.clk(hclk), .rst_n(hresetn), .req(req), .ctl(ctl));

  cpu_stage_clock_sequencer i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .run_in(ctl[5]), .nonpipe_select(ctl[4]),
    .irq_in(ctl[3]), .irq_enable(ctl[2]), .wait_in(ctl[1]),
    .wait_enable(ctl[0]), .stage1_early_clock(vec[0]),
    .ir_update_clock(vec[1]), .stage2_early_clock(vec[2]),
    .alu_update_clock(vec[3]), .stage3_early_clock(vec[4]),
    .stage3_late_clock(vec[5]), .free_a_clock(vec[6]),
    .free_b_clock(vec[7]));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // ----------
  // Checking
  // ----------
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Read data taken at the edge that closes the data phase
  always @(posedge hclk) begin
    if (rd_dp) begin
      cmp(hrdata, rq.pop_front());
    end
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end

  // Negedge sampling keeps clear of the launching edge
  always @(negedge hclk) begin
    if (q.size() > 0) begin
      cmp(32'(vec), 32'(q.pop_front()));
    end
  end

  // ----------
  // Drivers
  // ----------
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    if (!w) rq.push_back(d);
    wait_rdy();
  endtask

  task automatic do_reset(input int n);
    @(posedge hclk);
    hresetn <= 1'b0;
    req <= 6'h00;
    q.push_back(8'h00);
    repeat (n) begin
      @(posedge hclk);
      q.push_back(8'h00);
    end
    hresetn <= 1'b1;
    @(posedge hclk);
    q.push_back(8'h40);
    @(posedge hclk);
    q.push_back(8'h80);
  endtask

  task automatic wait_idle();
    int i;
    i = 0;
    do begin
      @(negedge hclk);
      i++;
    end while (vec !== 8'h40 && i < 20);
    if (vec !== 8'h40) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic play(input int first, input int n);
    logic [7:0] r;
    for (int k = first; k < first + n; k++) begin
      @(posedge hclk);
      r = tab[k][15:8];
      if (r[7]) r = r | (8'($random(seed)) & 8'h0a);
      req <= r[5:0];
      q.push_back(tab[k][7:0]);
    end
  endtask

  initial begin
    seed = 92;
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    req = 6'h00;
    mismatches = 0;
    n_compared = 0;
    do_reset(5);
    ahb(1'b0, {28'h0, seq_pkg::ctrl_off}, seq_pkg::ctrl_rst);
    ahb(1'b1, {28'h0, seq_pkg::ctrl_off}, 32'h2);
    ahb(1'b0, {28'h0, seq_pkg::ctrl_off}, 32'h2);
    ahb(1'b1, 32'hc, $random(seed));
    ahb(1'b0, 32'hc, 32'h0);
    ahb(1'b1, {28'h0, seq_pkg::ctrl_off}, 32'h0);
    wait_idle();
    play(0, 39);
    wait_idle();
    play(39, 25);
    wait_idle();
    play(0, 12);
    do_reset(2);
    wait_idle();
    ahb(1'b0, {28'h0, seq_pkg::state_off}, 32'(seq_pkg::st_free_b));
    ahb(1'b0, {28'h0, seq_pkg::status_off}, 32'h40);
    end_of_test();
  end
endmodule
`default_nettype wire
